// *** common/rsup_pkg.sv ***
// Package: register map, fields, timing counts and carrier structs of the reset and supply supervisor
// Behaviour
// R1 - Reset pin is an input for external requests and an open-drain output for internal sources.
// R2 - External low on the reset pin is caught asynchronously, even while halted.
// R3 - Watchdog underflow drives the reset pin low for at least a minimum pulse time.
// R4 - Low-voltage output holds a static reset while supply is below threshold.
// R5 - During a low-voltage reset the reset pin is driven low for board devices.
// R6 - Low-voltage reset exists only when a non-volatile option enables it.
// R7 - Low-voltage threshold is one of three levels chosen by an option read at startup.
// R8 - Low-voltage reset after a watchdog reset wins and clears the watchdog flag.
// R9 - Supply-warning comparator output is a read-only real-time flag; writes do nothing.
// R10 - Supply-warning threshold comes from a two-bit field in the threshold register.
// R11 - With enable set, each warning threshold crossing in either direction raises an interrupt.
// R12 - Warning interrupt reaches the CPU only with enable set and CPU mask cleared.
// R13 - In Wait the supervisor keeps running and a warning interrupt wakes the device.
// R14 - In Halt the integrity status register freezes and warning interrupts do not wake.
// R15 - Clock-output enable resets to 0; at 1 the main clock drives the shared pin.
// R16 - Slow-mode bit resets to 0; at 1 CPU clock is oscillator clock divided by 32.
// R17 - Software writes zeros to the six upper bits of the main clock register.
// R18 - After the active phase internal reset holds 256 or 4096 CPU cycles per clock source.
// R19 - Watchdog flag is set by watchdog reset, cleared by writing zero or low-voltage reset.
// R20 - Low-voltage flag is set by low-voltage reset, cleared by reading, kept through other resets.
// R21 - Asynchronous reset request is released through a two-stage synchroniser onto the clock.
package rsup_pkg;
  localparam logic [31:0] CLK_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] INTEG_ADDR = 32'h0000_0004;
  localparam logic [31:0] THCR_ADDR = 32'h0000_0008;
  localparam int CLK_OUT_BIT = 1;
  localparam int SLOW_BIT = 0;
  localparam int WDG_FLAG_BIT = 4;
  localparam int LV_FLAG_BIT = 2;
  localparam int WARN_FLAG_BIT = 1;
  localparam int WARN_IE_BIT = 0;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
  localparam logic [1:0] THSEL_RESET = 2'h0;
  localparam logic [4:0] SLOW_DIV_LAST = 5'h1F;
  localparam int CLK_MHZ = 50;
  localparam int WDG_PULSE_NS = 500;
  localparam int WDG_PULSE_CYC = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [12:0] DELAY_SHORT = 13'h0100;
  localparam logic [12:0] DELAY_LONG = 13'h1000;
  localparam int WDG_CNT_W = 8;

  typedef enum logic [1:0] {
    RST_RUN,
    RST_ACTIVE,
    RST_DELAY
  } rst_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic sel;
  } ahb_addr_s;
endpackage : rsup_pkg

// *** hdl/rsup_clkdiv.sv ***
// Divide-by-32 enable generator for slow mode
`timescale 1ns/1ps
module rsup_clkdiv (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  output logic cpu_en_out
);
  import rsup_pkg::*;
  logic [4:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || !slow_in) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign cpu_en_out = !slow_in || (cnt_q == SLOW_DIV_LAST); // R16
endmodule : rsup_clkdiv

// *** hdl/rsup_sync2.sv ***
// Two-stage synchroniser with asynchronous assert, clocked release
`timescale 1ns/1ps
module rsup_sync2 (
  input wire logic clk_in,
  input wire logic arst_in,
  output logic rel_out
);
  logic [1:0] sync_q;

  always_ff @(posedge clk_in or posedge arst_in) begin
    if (arst_in) begin
      sync_q <= 2'b11;
    end else begin
      sync_q <= {sync_q[0], 1'b0}; // R21
    end
  end

  assign rel_out = sync_q[1];
endmodule : rsup_sync2

// *** hdl/rsup_top.sv ***
// Reset sequencer, supply supervisor and main clock control with AHB-Lite registers
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module rsup_top (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic RESET_PIN_IN,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE_OUT,
  input wire logic WDG_UNDERFLOW_IN,
  input wire logic LOW_VOLTAGE_DETECTOR_IN,
  input wire logic LOW_VOLTAGE_OPTION_EN_IN,
  input wire logic [1:0] LOW_VOLTAGE_LEVEL_OPT_IN,
  input wire logic LONG_DELAY_OPT_IN,
  input wire logic SUPPLY_WARNING_DETECTOR_IN,
  input wire logic CPU_IRQ_MASK_IN,
  input wire logic CPU_IRQ_ACK_IN,
  input wire logic WAIT_MODE_IN,
  input wire logic HALT_MODE_IN,
  input wire logic OSCILLATOR_CLOCK_IN,
  output logic [1:0] LOW_VOLTAGE_LEVEL_OUT,
  output logic LOW_VOLTAGE_ENABLE_OUT,
  output logic [1:0] WARNING_THRESHOLD_SEL_OUT,
  output logic INTERNAL_RESET_OUT,
  output logic SUPPLY_WARNING_IRQ_OUT,
  output logic WAKE_OUT,
  output logic CLOCK_OUTPUT_ENABLE_OUT,
  output logic CLOCK_PIN_OUT,
  output logic CPU_CLK_EN_OUT
);
  import rsup_pkg::*;

  typedef struct packed {
    ahb_addr_s ap;
    logic [31:0] rdata;
    logic clock_output_enable;
    logic slow_mode_select;
    logic [1:0] warning_threshold_sel;
    logic supply_warning_irq_en;
    logic watchdog_reset_flag;
    logic low_voltage_reset_flag;
    logic supply_warning_flag;
    logic warn_prev;
    logic irq_pend;
    logic opt_lv_en;
    logic [1:0] opt_level;
    logic opt_long;
    logic opt_taken;
    rst_state_e phase;
    logic [12:0] dly;
    logic [7:0] wdg_cnt;
    logic pin_low;
    logic int_rst;
    logic irq;
    logic wake;
    logic clk_pin;
    logic cpu_en;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic ext_rel;
  logic cpu_en;
  logic lv_low;
  logic wr_go;
  logic rd_go;

  // External low sets the synchroniser without a clock, so halted parts still reset
  rsup_sync2 u_sync (
    .clk_in(REF_CLK_IN),
    // Own pull-down masked, else the delay phase would retrigger itself
    .arst_in((!RESET_PIN_IN && !s_q.pin_low) || SYS_RST_IN), // R2
    .rel_out(ext_rel)
  );

  rsup_clkdiv u_div (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .slow_in(s_q.slow_mode_select),
    .cpu_en_out(cpu_en)
  );

  function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
    hit = (a[7:2] == base[7:2]);
  endfunction : hit

  assign lv_low = s_q.opt_lv_en && LOW_VOLTAGE_DETECTOR_IN; // R6
  assign wr_go = s_q.ap.sel && s_q.ap.write;
  assign rd_go = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;

  always_comb begin
    s_d = s_q;
    s_d.ap.sel = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    s_d.ap.addr = HADDR_IN;
    s_d.ap.write = HWRITE_IN;
    // Options latched once after reset release, never from reset itself
    if (!s_q.opt_taken) begin
      s_d.opt_lv_en = LOW_VOLTAGE_OPTION_EN_IN;
      s_d.opt_level = LOW_VOLTAGE_LEVEL_OPT_IN; // R7
      s_d.opt_long = LONG_DELAY_OPT_IN;
      s_d.opt_taken = 1'b1;
    end
    // Register writes in data phase
    if (wr_go) begin
      if (hit(s_q.ap.addr, CLK_CTRL_ADDR)) begin
        s_d.clock_output_enable = HWDATA_IN[CLK_OUT_BIT];
        s_d.slow_mode_select = HWDATA_IN[SLOW_BIT];
      end
      if (hit(s_q.ap.addr, INTEG_ADDR) && !HALT_MODE_IN) begin
        s_d.supply_warning_irq_en = HWDATA_IN[WARN_IE_BIT];
        if (!HWDATA_IN[WDG_FLAG_BIT]) begin
          s_d.watchdog_reset_flag = 1'b0; // R19
        end
      end
      if (hit(s_q.ap.addr, THCR_ADDR)) begin
        s_d.warning_threshold_sel = HWDATA_IN[1:0]; // R10
      end
    end
    // Reads return a stable word captured at the address phase
    s_d.rdata = 32'h0000_0000;
    if (rd_go) begin
      if (hit(HADDR_IN, CLK_CTRL_ADDR)) begin
        s_d.rdata[CLK_OUT_BIT] = s_q.clock_output_enable;
        s_d.rdata[SLOW_BIT] = s_q.slow_mode_select;
      end else if (hit(HADDR_IN, INTEG_ADDR)) begin
        s_d.rdata[WDG_FLAG_BIT] = s_q.watchdog_reset_flag;
        s_d.rdata[LV_FLAG_BIT] = s_q.low_voltage_reset_flag;
        s_d.rdata[WARN_FLAG_BIT] = s_q.supply_warning_flag; // R9
        s_d.rdata[WARN_IE_BIT] = s_q.supply_warning_irq_en;
        if (!HALT_MODE_IN) begin
          s_d.low_voltage_reset_flag = 1'b0; // R20
        end
      end else if (hit(HADDR_IN, THCR_ADDR)) begin
        s_d.rdata[1:0] = s_q.warning_threshold_sel;
      end
    end
    // Supply warning: status frozen in Halt, comparator value tracked otherwise
    if (!HALT_MODE_IN) begin
      s_d.supply_warning_flag = SUPPLY_WARNING_DETECTOR_IN; // R9 R14
      s_d.warn_prev = s_q.supply_warning_flag;
      if (CPU_IRQ_ACK_IN) begin
        s_d.irq_pend = 1'b0;
      end
      // Set beats acknowledge in the same cycle
      if (s_q.supply_warning_irq_en && (s_q.supply_warning_flag != s_q.warn_prev)) begin
        s_d.irq_pend = 1'b1; // R11
      end
    end
    if (!s_q.supply_warning_irq_en) begin
      s_d.irq_pend = 1'b0;
    end
    s_d.irq = s_d.irq_pend && s_d.supply_warning_irq_en && !CPU_IRQ_MASK_IN; // R12
    s_d.wake = s_d.irq && WAIT_MODE_IN && !HALT_MODE_IN; // R13 R14
    // Watchdog pulse stretcher
    if (WDG_UNDERFLOW_IN) begin
      s_d.wdg_cnt = WDG_CNT_W'(WDG_PULSE_CYC); // R3
      s_d.watchdog_reset_flag = 1'b1; // R19
    end else if (s_q.wdg_cnt != '0) begin
      s_d.wdg_cnt = s_q.wdg_cnt - 8'h01;
    end
    if (lv_low) begin
      s_d.low_voltage_reset_flag = 1'b1; // R20
      s_d.watchdog_reset_flag = 1'b0; // R8
    end
    // Reset sequencer
    case (s_q.phase)
      RST_RUN: begin
        if (ext_rel || lv_low || s_d.wdg_cnt != '0) begin
          s_d.phase = RST_ACTIVE;
        end
      end
      RST_ACTIVE: begin
        if (!ext_rel && !lv_low && s_d.wdg_cnt == '0) begin // R4
          s_d.phase = RST_DELAY;
          s_d.dly = s_q.opt_long ? DELAY_LONG : DELAY_SHORT; // R18
        end
      end
      RST_DELAY: begin
        if (ext_rel || lv_low || s_d.wdg_cnt != '0) begin
          s_d.phase = RST_ACTIVE;
        end else if (cpu_en) begin
          if (s_q.dly == 13'h0001) begin
            s_d.phase = RST_RUN;
          end
          s_d.dly = s_q.dly - 13'h0001; // R18
        end
      end
      default: begin
        s_d.phase = RST_ACTIVE;
      end
    endcase
    s_d.int_rst = (s_d.phase != RST_RUN);
    // Pin pulled low for internal sources and throughout the delay
    s_d.pin_low = lv_low || (s_d.wdg_cnt != '0) || (s_d.phase == RST_DELAY); // R1 R5
    if (s_d.int_rst) begin
      s_d.clock_output_enable = 1'b0; // R15
      s_d.slow_mode_select = 1'b0; // R16
    end
    s_d.clk_pin = s_q.clock_output_enable && OSCILLATOR_CLOCK_IN; // R15
    s_d.cpu_en = cpu_en; // R16
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      s_q <= '0;
      s_q.phase <= RST_ACTIVE;
      s_q.int_rst <= 1'b1;
      s_q.warning_threshold_sel <= THSEL_RESET;
      s_q.clock_output_enable <= CLK_CTRL_RESET[CLK_OUT_BIT];
      s_q.slow_mode_select <= CLK_CTRL_RESET[SLOW_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave, always OKAY; upper bits of the clock register are ignored
  assign HRDATA_OUT = s_q.rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign RESET_PIN_OUT = 1'b0;
  assign RESET_PIN_OE_OUT = s_q.pin_low;
  assign LOW_VOLTAGE_LEVEL_OUT = s_q.opt_level;
  assign LOW_VOLTAGE_ENABLE_OUT = s_q.opt_lv_en;
  assign WARNING_THRESHOLD_SEL_OUT = s_q.warning_threshold_sel;
  assign INTERNAL_RESET_OUT = s_q.int_rst;
  assign SUPPLY_WARNING_IRQ_OUT = s_q.irq;
  assign WAKE_OUT = s_q.wake;
  assign CLOCK_OUTPUT_ENABLE_OUT = s_q.clock_output_enable;
  assign CLOCK_PIN_OUT = s_q.clk_pin;
  assign CPU_CLK_EN_OUT = s_q.cpu_en;
endmodule : rsup_top

// *** tb/rsup_board.sv ***
// Board side of the reset wire: pull-up, device pull-down, external pusher
`timescale 1ns/1ps
module rsup_board (
  input wire logic oe_in,
  input wire logic ext_low_in,
  output logic pin_out
);
  // Pull-up wins unless someone sinks the wire
  assign pin_out = ~(oe_in | ext_low_in);
endmodule : rsup_board

// *** tb/rsup_sva.sv ***
// Checker of reset, supervisor and clock relations at the top ports
`timescale 1ns/1ps
module rsup_sva (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic RESET_PIN_IN,
  input wire logic RESET_PIN_OUT,
  input wire logic RESET_PIN_OE_OUT,
  input wire logic WDG_UNDERFLOW_IN,
  input wire logic LOW_VOLTAGE_DETECTOR_IN,
  input wire logic LOW_VOLTAGE_ENABLE_OUT,
  input wire logic INTERNAL_RESET_OUT,
  input wire logic CPU_CLK_EN_OUT,
  input wire logic CPU_IRQ_MASK_IN,
  input wire logic SUPPLY_WARNING_IRQ_OUT,
  input wire logic HALT_MODE_IN,
  input wire logic WAKE_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_hold;
    RESET_PIN_OE_OUT [*8];
  endsequence
  sequence s_low;
    LOW_VOLTAGE_ENABLE_OUT && LOW_VOLTAGE_DETECTOR_IN;
  endsequence
  property p_od; RESET_PIN_OUT == 1'b0; endproperty
  a_od: assert property (p_od) else $error("reset pin driven high");
  property p_lvd; s_low |=> RESET_PIN_OE_OUT; endproperty
  a_lvd: assert property (p_lvd) else $error("pin free in low supply");
  property p_lrs; s_low |=> INTERNAL_RESET_OUT; endproperty
  a_lrs: assert property (p_lrs) else $error("no reset in low supply");
  property p_wdg; WDG_UNDERFLOW_IN |=> s_hold; endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog pulse short");
  property p_ext; !RESET_PIN_IN |-> ##[0:3] INTERNAL_RESET_OUT; endproperty
  a_ext: assert property (p_ext) else $error("pin low ignored");
  property p_div; !CPU_CLK_EN_OUT |-> ##[1:31] CPU_CLK_EN_OUT; endproperty
  a_div: assert property (p_div) else $error("cpu enable gap too long");
  property p_msk; CPU_IRQ_MASK_IN |=> !SUPPLY_WARNING_IRQ_OUT; endproperty
  a_msk: assert property (p_msk) else $error("irq while masked");
  property p_hlt; HALT_MODE_IN |=> !WAKE_OUT; endproperty
  a_hlt: assert property (p_hlt) else $error("wake in halt");
endmodule : rsup_sva
bind rsup_top rsup_sva SVA (.*);

// *** tb/testbench.sv ***
// Testbench: bus, reset sources and supervisor checks
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
  import rsup_pkg::*;
  logic clk = 0, rst = 1, sel = 0, wr = 0, wdg = 0, lvl = 0, swd = 0, msk = 1;
  logic ack = 0, wt = 0, hlt = 0, osc = 0, ext = 0, ok, resp, cen, lven;
  logic [1:0] tr = 0, lvo = 0, lvlo;
  logic [31:0] ad = 0, wd = 0, q, rdat, seed = 32'haac7, mc, th;
  logic rdy, pin, oe, irq, wake, irst, coe;
  logic [1:0] tsel;
  int err_total = 0, n_tests = 0, i, n, k;
  always #10 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  rsup_board BRD (.oe_in(oe), .ext_low_in(ext), .pin_out(pin));
  rsup_top DUT (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(sel), .HADDR_IN(ad), .HTRANS_IN(tr),
    .HWRITE_IN(wr), .HSIZE_IN(3'h2), .HWDATA_IN(wd), .HREADY_IN(rdy), .HRDATA_OUT(rdat),
    .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .RESET_PIN_IN(pin), .RESET_PIN_OUT(), .RESET_PIN_OE_OUT(oe),
    .WDG_UNDERFLOW_IN(wdg), .LOW_VOLTAGE_DETECTOR_IN(lvl), .LOW_VOLTAGE_OPTION_EN_IN(1'b1),
    .LOW_VOLTAGE_LEVEL_OPT_IN(lvo), .LONG_DELAY_OPT_IN(1'b0), .SUPPLY_WARNING_DETECTOR_IN(swd),
    .CPU_IRQ_MASK_IN(msk), .CPU_IRQ_ACK_IN(ack), .WAIT_MODE_IN(wt), .HALT_MODE_IN(hlt),
    .OSCILLATOR_CLOCK_IN(osc), .LOW_VOLTAGE_LEVEL_OUT(lvlo), .LOW_VOLTAGE_ENABLE_OUT(lven),
    .WARNING_THRESHOLD_SEL_OUT(tsel), .INTERNAL_RESET_OUT(irst), .SUPPLY_WARNING_IRQ_OUT(irq),
    .WAKE_OUT(wake), .CLOCK_OUTPUT_ENABLE_OUT(coe), .CLOCK_PIN_OUT(), .CPU_CLK_EN_OUT(cen));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Each phase held until ready is seen at a rising edge; read data taken at that edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    ad <= a;
    wr <= w;
    tr <= 2'b10;
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 1'b0;
    tr <= 2'b00;
    wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rdat;
  endtask : ahb
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(s, e, q & m)
    `CHK("hresp", 1'b0, resp)
  endtask : chk_rd
  task automatic run_wait();
    @(negedge clk);
    for (n = 0; n < 9000 && irst !== 1'b0; n++) @(negedge clk);
  endtask : run_wait
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic wdg_hit();
    @(posedge clk);
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    ok = 1'b1;
    repeat (WDG_PULSE_CYC) begin
      @(negedge clk);
      ok &= oe;
    end
    `CHK("wdg_pulse", 1'b1, ok)
    run_wait();
  endtask : wdg_hit
  initial begin
    q = xs();
    lvo <= q[1:0];
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    run_wait();
    `CHK("delay", 1'b1, n >= 256)
    `CHK("lv_level", lvo, lvlo)
    `CHK("lv_en", 1'b1, lven)
    chk_rd(CLK_CTRL_ADDR, 32'hFF, CLK_CTRL_RESET, "clkctl_rst");
    chk_rd(THCR_ADDR, 32'h03, 32'h0000_0000, "thcr_rst");
    for (i = 0; i < 4; i++) begin
      mc = i;
      ahb(1'b1, CLK_CTRL_ADDR, mc);
      chk_rd(CLK_CTRL_ADDR, 32'hFF, mc, "clkctl");
      `CHK("clk_out_en", mc[1], coe)
      k = 0;
      repeat (64) begin
        @(negedge clk);
        k += cen;
      end
      `CHK("cpu_en", mc[0] ? 2 : 64, k)
      th = xs() & 32'h3;
      ahb(1'b1, THCR_ADDR, th);
      chk_rd(THCR_ADDR, 32'h03, th, "thcr");
      `CHK("thsel", th[1:0], tsel)
    end
    chk_rd(32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    ahb(1'b1, INTEG_ADDR, 32'h0000_0003);
    chk_rd(INTEG_ADDR, 32'h03, 32'h0000_0001, "warn_ro");
    @(posedge clk);
    msk <= 1'b0;
    wt <= 1'b1;
    swd <= 1'b1;
    for (i = 0; i < 10 && irq !== 1'b1; i++) @(negedge clk);
    `CHK("irq_fall", 1'b1, irq)
    @(negedge clk);
    `CHK("wake", 1'b1, wake)
    chk_rd(INTEG_ADDR, 32'h02, 32'h0000_0002, "warn_flag");
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    swd <= 1'b0;
    for (i = 0; i < 10 && irq !== 1'b1; i++) @(negedge clk);
    `CHK("irq_rise", 1'b1, irq)
    @(posedge clk);
    hlt <= 1'b1;
    repeat (4) @(posedge clk);
    hlt <= 1'b0;
    wt <= 1'b0;
    msk <= 1'b1;
    wdg_hit();
    chk_rd(INTEG_ADDR, 32'h10, 32'h0000_0010, "wdg_flag");
    ahb(1'b1, INTEG_ADDR, 32'h0000_0000);
    chk_rd(INTEG_ADDR, 32'h10, 32'h0000_0000, "wdg_w0c");
    wdg_hit();
    @(posedge clk);
    lvl <= 1'b1;
    repeat (5) @(negedge clk);
    `CHK("lv_pin", 1'b1, oe)
    @(posedge clk);
    lvl <= 1'b0;
    run_wait();
    @(posedge clk);
    ext <= 1'b1;
    repeat (3) @(posedge clk);
    ext <= 1'b0;
    @(negedge clk);
    `CHK("ext_rst", 1'b1, irst)
    run_wait();
    chk_rd(INTEG_ADDR, 32'h14, 32'h0000_0004, "lv_flag");
    chk_rd(INTEG_ADDR, 32'h04, 32'h0000_0000, "lv_rdclr");
    wrap_up();
  end
  // Five reset sequences of about 300 cycles each plus bus work fit well inside this
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : testbench
